// [verilog/spi_cfg_pkg.sv]
package spi_cfg_pkg;

  // ==========================================================
  // register map, byte offsets on the plain register port
  localparam int         ADDR_W       = 8;
  localparam int         DATA_W       = 16;
  localparam logic [7:0] OFF_DATA     = 8'h0c;
  localparam logic [7:0] OFF_CTRL     = 8'h0d;
  localparam logic [7:0] OFF_FMT      = 8'h0e;
  localparam logic [7:0] OFF_DIV      = 8'h0f;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h11;

  // ==========================================================
  // reset values and field layouts
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [3:0] IRQ_MASK_RESET = 4'hf;
  localparam logic [7:0] FMT_RW_MASK    = 8'h87;
  localparam int         FMT_CPOL       = 0;
  localparam int         FMT_CPHA       = 1;
  localparam int         FMT_CHR        = 2;
  localparam int         FMT_IRQEN      = 7;
  localparam int         CTL_EN         = 0;
  localparam int         CTL_MST        = 1;
  localparam int         CTL_MODFE      = 2;
  localparam int         CTL_FLAG_LO    = 3;
  localparam int         CTL_FLAG_HI    = 6;
  localparam int         CTL_BUSY       = 7;
  // event bits, same order as the control flags
  localparam int         EV_MODE_FAULT_FLAG        = 0;
  localparam int         EV_WRITE_COLLISION_FLAG        = 1;
  localparam int         EV_RECEIVE_OVERRUN_FLAG        = 2;
  localparam int         EV_DONE        = 3;
  localparam int         MSB8           = 7;
  localparam int         MSB16          = 15;
  localparam logic [4:0] LAST_BIT8      = 5'h07;
  localparam logic [4:0] LAST_BIT16     = 5'h0f;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_XFER = 2'b10
  } xfer_st_e;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_s;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic miso;
    logic ssel_n;
  } spi_in_s;

  typedef struct packed {
    logic sclk_o;
    logic sclk_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } spi_out_s;

endpackage

// [verilog/spi_format_and_baud_config.sv]
// How it works
// R01: polarity bit picks falling or rising active edge
// R02: phase bit picks sampling on inactive edge
// R03: length bit picks 8 or 16 bit characters
// R04: interrupt enable gates the four flag interrupts
// R05: format bits six to three read zero
// R06: divider register holds ratio 0 to 255
// R07: master clock is half sysclk over ratio+1
// R08: divider ignored and halted in slave mode
// R09: format and divider readable, writable, reset zero
// R10: module enable gates controller and baud generator
// R11: master bit rises only with select deasserted
// R12: busy flag high throughout a transfer cycle
// R13: done flag sticky, software one raises interrupt
// R14: msb first, clock idles at polarity level
// R15: one clock period per bit transferred
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
module spi_format_and_baud_config
  import spi_cfg_pkg::*;
(
  input  logic        clk_sys, // system clock
  input  logic        reset,   // synchronous reset, high
  input  bus_req_s    bus_i,   // register port request
  output logic [15:0] rdata_o, // read data, cycle after read
  input  spi_in_s     spi_i,   // serial pin inputs
  output spi_out_s    spi_o,   // serial pin outputs and enables
  output logic        irq_o    // level interrupt
);

  // ==========================================================
  // state
  typedef struct packed {
    xfer_st_e    st;
    logic [7:0]  fmt;
    logic [7:0]  div;
    logic        en;
    logic        mst;
    logic        modfe;
    logic [3:0]  flag;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_mask;
    logic [15:0] tx;
    logic [15:0] rx;
    logic [15:0] rdbuf;
    logic        rx_full;
    logic [7:0]  baud;
    logic [4:0]  bitn;
    logic        lead;
    logic        cpha;
    logic        len16;
    logic        sclk;
    logic        dout;
    logic        sclk_prev;
    logic        ssel_prev;
    logic [15:0] rdata;
  } st_s;

  st_s        s_r;
  st_s        s_nxt;
  logic [3:0] ev;
  logic [3:0] swset;
  logic [3:0] w1c;
  logic [15:0] rx_v;
  logic [15:0] tx_v;
  logic       edge_v;
  logic       abort;
  logic       start;
  logic       din;
  logic       wr_data;
  logic       rd_data;
  logic       ss_fall;
  logic       full_v;

  function automatic logic msb_of(input logic [15:0] d, input logic len16);
    return len16 ? d[MSB16] : d[MSB8];
  endfunction

  function automatic logic [15:0] shl(input logic [15:0] d);
    return {d[14:0], 1'b0};
  endfunction

  // ==========================================================
  // next state
  always_comb
  begin
    s_nxt = s_r;
    ev = 4'h0;
    swset = 4'h0;
    w1c = 4'h0;
    rx_v = s_r.rx;
    tx_v = s_r.tx;
    edge_v = 1'b0;
    abort = 1'b0;
    start = 1'b0;
    wr_data = bus_i.wr && (bus_i.addr == OFF_DATA);
    rd_data = bus_i.rd && (bus_i.addr == OFF_DATA);
    ss_fall = s_r.ssel_prev && !spi_i.ssel_n;
    full_v = s_r.rx_full && !rd_data;
    din = s_r.mst ? spi_i.miso : spi_i.mosi;
    s_nxt.ssel_prev = spi_i.ssel_n;
    s_nxt.sclk_prev = spi_i.sclk;
    s_nxt.rdata = 16'h0000;

    // read side first so a completing transfer can refill the buffer
    if (bus_i.rd)
    begin
      case (bus_i.addr)
        OFF_DATA:     s_nxt.rdata = s_r.rdbuf;
        OFF_CTRL:     s_nxt.rdata = {8'h00, (s_r.st == ST_XFER), s_r.flag, s_r.modfe, s_r.mst, s_r.en}; // [R12]
        OFF_FMT:      s_nxt.rdata = {8'h00, s_r.fmt & FMT_RW_MASK}; // [R05] [R09]
        OFF_DIV:      s_nxt.rdata = {8'h00, s_r.div}; // [R06] [R09]
        OFF_IRQ_STAT: s_nxt.rdata = {12'h000, s_r.irq_stat};
        OFF_IRQ_MASK: s_nxt.rdata = {12'h000, s_r.irq_mask};
        default:      s_nxt.rdata = 16'h0000;
      endcase
      if (rd_data)
        s_nxt.rx_full = 1'b0;
    end

    if (s_r.en && s_r.mst && s_r.modfe && ss_fall)
    begin
      ev[EV_MODE_FAULT_FLAG] = 1'b1;
      abort = 1'b1;
    end
    // data written mid-character is dropped, not queued
    if (wr_data && (s_r.st == ST_XFER))
      ev[EV_WRITE_COLLISION_FLAG] = 1'b1;

    case (s_r.st)
      ST_IDLE:
      begin
        if (wr_data)
          s_nxt.tx = bus_i.wdata;
        tx_v = wr_data ? bus_i.wdata : s_r.tx;
        start = s_r.en && !abort && (s_r.mst ? wr_data : ss_fall); // [R10]
        if (start)
        begin
          s_nxt.st = ST_XFER; // [R12]
          s_nxt.bitn = 5'h00;
          s_nxt.lead = 1'b1;
          s_nxt.baud = 8'h00;
          s_nxt.cpha = s_r.fmt[FMT_CPHA];
          s_nxt.len16 = s_r.fmt[FMT_CHR]; // [R03]
          s_nxt.tx = tx_v;
          if (!s_r.fmt[FMT_CPHA])
          begin
            s_nxt.dout = msb_of(tx_v, s_r.fmt[FMT_CHR]); // [R14]
            s_nxt.tx = shl(tx_v);
          end
        end
      end
      ST_XFER:
      begin
        if (s_r.mst)
        begin
          if (s_r.baud == s_r.div) // [R07]
          begin
            s_nxt.baud = 8'h00;
            edge_v = 1'b1;
          end
          else
            s_nxt.baud = 8'(s_r.baud + 8'h01);
        end
        else
          edge_v = (spi_i.sclk != s_r.sclk_prev);
        if (!s_r.en || abort || (!s_r.mst && spi_i.ssel_n))
          s_nxt.st = ST_IDLE; // [R10]
        else if (edge_v)
        begin
          if (s_r.mst)
            s_nxt.sclk = !s_r.sclk; // [R01] [R15]
          if (s_r.lead)
          begin
            s_nxt.lead = 1'b0;
            if (!s_r.cpha)
              rx_v = {s_r.rx[14:0], din}; // [R02]
            else
            begin
              s_nxt.dout = msb_of(s_r.tx, s_r.len16); // [R14]
              s_nxt.tx = shl(s_r.tx);
            end
          end
          else
          begin
            s_nxt.lead = 1'b1;
            if (s_r.cpha)
              rx_v = {s_r.rx[14:0], din}; // [R02]
            if (s_r.bitn == (s_r.len16 ? LAST_BIT16 : LAST_BIT8)) // [R03] [R15]
            begin
              s_nxt.st = ST_IDLE; // [R12]
              ev[EV_DONE] = 1'b1; // [R13]
              // overrun keeps the older character
              if (full_v)
                ev[EV_RECEIVE_OVERRUN_FLAG] = 1'b1;
              else
              begin
                s_nxt.rdbuf = s_r.len16 ? rx_v : {8'h00, rx_v[7:0]};
                s_nxt.rx_full = 1'b1;
              end
            end
            else
            begin
              s_nxt.bitn = 5'(s_r.bitn + 5'h01);
              if (!s_r.cpha)
              begin
                s_nxt.dout = msb_of(s_r.tx, s_r.len16);
                s_nxt.tx = shl(s_r.tx);
              end
            end
          end
          s_nxt.rx = rx_v;
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase

    if (bus_i.wr)
    begin
      case (bus_i.addr)
        OFF_FMT: s_nxt.fmt = bus_i.wdata[7:0] & FMT_RW_MASK; // [R05] [R09]
        OFF_DIV: s_nxt.div = bus_i.wdata[7:0]; // [R06] [R09]
        OFF_CTRL:
        begin
          s_nxt.en = bus_i.wdata[CTL_EN];
          s_nxt.modfe = bus_i.wdata[CTL_MODFE];
          // refused rise keeps a selected slave from being overdriven
          if (bus_i.wdata[CTL_MST] && !s_r.mst && !spi_i.ssel_n)
            s_nxt.mst = 1'b0; // [R11]
          else
            s_nxt.mst = bus_i.wdata[CTL_MST];
          s_nxt.flag = bus_i.wdata[CTL_FLAG_HI:CTL_FLAG_LO];
          swset = bus_i.wdata[CTL_FLAG_HI:CTL_FLAG_LO]; // [R13]
        end
        OFF_IRQ_STAT: w1c = bus_i.wdata[3:0];
        OFF_IRQ_MASK: s_nxt.irq_mask = bus_i.wdata[3:0];
        default: ;
      endcase
    end

    // hardware set wins over a same-cycle clear
    s_nxt.flag = s_nxt.flag | ev; // [R13]
    s_nxt.irq_stat = (s_r.irq_stat & ~w1c) | ev | swset;
    if (s_nxt.st == ST_IDLE)
      s_nxt.sclk = s_nxt.fmt[FMT_CPOL]; // [R14] [R01]
    if (!s_nxt.en || !s_nxt.mst)
      s_nxt.baud = 8'h00; // [R08] [R10]
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.fmt <= REG_RESET; // [R09]
      s_r.div <= REG_RESET;
      s_r.irq_mask <= IRQ_MASK_RESET;
      s_r.ssel_prev <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // ==========================================================
  // outputs
  assign rdata_o = s_r.rdata;
  assign irq_o = s_r.fmt[FMT_IRQEN] && (|(s_r.irq_stat & s_r.irq_mask)); // [R04]
  assign spi_o.sclk_o = s_r.sclk;
  assign spi_o.sclk_oe = s_r.en && s_r.mst;
  assign spi_o.mosi_o = s_r.dout;
  assign spi_o.mosi_oe = s_r.en && s_r.mst;
  assign spi_o.miso_o = s_r.dout;
  assign spi_o.miso_oe = s_r.en && !s_r.mst && !spi_i.ssel_n;

  // ==========================================================
  // checks
  property p_half_period;
    @(posedge clk_sys) disable iff (reset)
    ($past(s_r.st) == ST_XFER) && $past(s_r.mst) && $changed(s_r.sclk) && (s_r.st == ST_XFER)
      |-> ($past(s_r.baud) == $past(s_r.div));
  endproperty
  a_half_period: assert property (p_half_period) else $error("sclk toggled off divider count"); // [R07]

  property p_fmt_reserved;
    @(posedge clk_sys) disable iff (reset)
    (bus_i.rd && (bus_i.addr == OFF_FMT)) |=> (rdata_o[6:3] == 4'h0) && (rdata_o[15:8] == 8'h00);
  endproperty
  a_fmt_reserved: assert property (p_fmt_reserved) else $error("reserved format bits not zero"); // [R05]

  property p_reset_clear;
    @(posedge clk_sys)
    reset |=> (s_r.fmt == REG_RESET) && (s_r.div == REG_RESET) && (s_r.st == ST_IDLE);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("registers not cleared by reset"); // [R09]

  property p_irq_gate;
    @(posedge clk_sys) disable iff (reset)
    !s_r.fmt[FMT_IRQEN] |-> !irq_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt raised while disabled"); // [R04]

  property p_busy_start;
    @(posedge clk_sys) disable iff (reset)
    (bus_i.wr && (bus_i.addr == OFF_DATA) && s_r.en && s_r.mst && (s_r.st == ST_IDLE) && !ss_fall)
      |=> (s_r.st == ST_XFER);
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not set on transfer start"); // [R12]

  property p_done_sticky;
    @(posedge clk_sys) disable iff (reset)
    ev[EV_DONE] |=> s_r.flag[EV_DONE] && s_r.irq_stat[EV_DONE] ##1 (s_r.flag[EV_DONE] || $past(bus_i.wr));
  endproperty
  a_done_sticky: assert property (p_done_sticky) else $error("done flag lost"); // [R13]

  property p_master_guard;
    @(posedge clk_sys) disable iff (reset)
    (bus_i.wr && (bus_i.addr == OFF_CTRL) && bus_i.wdata[CTL_MST] && !s_r.mst && !spi_i.ssel_n) |=> !s_r.mst;
  endproperty
  a_master_guard: assert property (p_master_guard) else $error("master set while selected"); // [R11]

  property p_slave_divider;
    @(posedge clk_sys) disable iff (reset)
    (!s_r.mst || !s_r.en) |-> (s_r.baud == 8'h00);
  endproperty
  a_slave_divider: assert property (p_slave_divider) else $error("divider running in slave or disabled"); // [R08]

  property p_idle_level;
    @(posedge clk_sys) disable iff (reset)
    (s_r.st == ST_IDLE) |-> (s_r.sclk == s_r.fmt[FMT_CPOL]);
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("sclk not at idle level"); // [R14]

  property p_disable_stops;
    @(posedge clk_sys) disable iff (reset)
    (!s_r.en && (s_r.st == ST_XFER)) |=> (s_r.st == ST_IDLE) [*2];
  endproperty
  a_disable_stops: assert property (p_disable_stops) else $error("transfer kept running when disabled"); // [R10]

endmodule

// [tb/spi_slave_model.sv]
`timescale 1ns/10ps
module spi_slave_model (
  input  wire logic        sclk,  // clock from master
  input  wire logic        mosi,  // data from master
  input  wire logic        sel_n, // select, low active
  input  wire logic        cpol,  // idle level
  input  wire logic        cpha,  // sample on trailing edge
  input  wire logic        len16, // 16 bit characters
  input  wire logic [15:0] tx,    // word to return
  output logic             miso,  // data to master
  output logic [15:0]      rx     // word received
);
  logic [15:0] sh;
  logic        first;
  initial miso = 1'b0;
  // ==========
  // load on select; no pull on miso, so released it flips
  always @(negedge sel_n)
  begin
    sh = tx;
    rx = 16'h0000;
    first = cpha;
    miso = len16 ? tx[15] : tx[7];
  end
  always @(posedge sel_n) miso = ~miso;
  always @(sclk)
    if (!sel_n)
    begin
      if ((sclk != cpol) ^ cpha)
        rx = {rx[14:0], mosi};
      else if (first)
        first = 1'b0;
      else
      begin
        sh = {sh[14:0], 1'b0};
        miso = len16 ? sh[15] : sh[7];
      end
    end
endmodule

// [tb/spi_format_and_baud_config_bench.sv]
`timescale 1ns/10ps
module spi_format_and_baud_config_bench
  import spi_cfg_pkg::*;
;
  typedef struct packed {
    logic [7:0]  fmt;
    logic [7:0]  div;
    logic [15:0] tx;
    logic [15:0] stx;
  } row_s;
  logic        clk_sys;
  logic        reset;
  bus_req_s    bus_i;
  logic [15:0] rdata_o;
  spi_in_s     spi_i;
  spi_out_s    spi_o;
  logic        irq_o;
  logic        m_miso;
  logic [15:0] m_rx;
  logic        m_sel_n;
  logic        ssel_n;
  logic [7:0]  cur_fmt;
  logic [15:0] m_tx;
  logic [15:0] got;
  logic [15:0] msk;
  logic        sclk_d;
  logic        s_sclk;
  logic        s_mosi;
  logic [7:0]  ext_got;
  localparam logic [7:0] EXT_WORD = 8'h3a;
  int          len;
  int          error_cnt;
  int          n_compared;
  int          cyc;
  int          tog;
  int          t_first;
  int          t_last;
  row_s        rows [5];

  // ==========
  // harness
  assign spi_i = '{sclk: s_sclk, mosi: s_mosi, miso: m_miso, ssel_n: ssel_n};
  spi_format_and_baud_config dut (
    .clk_sys (clk_sys),
    .reset   (reset),
    .bus_i   (bus_i),
    .rdata_o (rdata_o),
    .spi_i   (spi_i),
    .spi_o   (spi_o),
    .irq_o   (irq_o)
  );
  spi_slave_model partner (
    .sclk  (spi_o.sclk_o),
    .mosi  (spi_o.mosi_o),
    .sel_n (m_sel_n),
    .cpol  (cur_fmt[FMT_CPOL]),
    .cpha  (cur_fmt[FMT_CPHA]),
    .len16 (cur_fmt[FMT_CHR]),
    .tx    (m_tx),
    .miso  (m_miso),
    .rx    (m_rx)
  );
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // serial clock edge log, used for period and count checks
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    sclk_d <= spi_o.sclk_o;
    if (spi_o.sclk_o !== sclk_d)
    begin
      tog <= tog + 1;
      t_last <= cyc;
      if (tog == 0)
        t_first <= cyc;
    end
  end

  // ==========
  // tasks
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    bus_i.addr <= a;
    bus_i.wdata <= d;
    bus_i.wr <= 1'b1;
    @(posedge clk_sys);
    bus_i.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    bus_i.addr <= a;
    bus_i.rd <= 1'b1;
    @(posedge clk_sys);
    bus_i.rd <= 1'b0;
    #1 got = rdata_o;
  endtask
  task automatic wait_idle;
    int k;
    k = 0;
    do
    begin
      rd(OFF_CTRL);
      k++;
    end while (got[CTL_BUSY] !== 1'b0 && k < 10000);
    chk("busy", 16'h0000, {15'h0, got[CTL_BUSY]});
  endtask
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    error_cnt++;
    summarize();
  end

  // ==========
  // tests
  initial
  begin
    rows = '{'{8'h00, 8'h00, 16'h00a5, 16'h003c}, '{8'h79, 8'h01, 16'h00c3, 16'h0096},
             '{8'h82, 8'h02, 16'h005a, 16'h00e1}, '{8'h87, 8'h00, 16'hb38d, 16'h4c72},
             '{8'h04, 8'hff, 16'h8001, 16'h7ffe}};
    bus_i = '0;
    reset = 1'b1;
    ssel_n = 1'b1;
    m_sel_n = 1'b1;
    cur_fmt = 8'h00;
    m_tx = 16'h0000;
    s_sclk = 1'b0;
    s_mosi = 1'b0;
    error_cnt = 0;
    n_compared = 0;
    cyc = 0;
    tog = 0;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      rd((i == 3) ? OFF_IRQ_MASK : OFF_CTRL + 8'(i));
      chk("reset value", (i == 3) ? 16'h000f : 16'h0000, got);
    end
    wr(8'h20, 16'h00ff);
    rd(8'h20);
    chk("unmapped", 16'h0000, got);
    $display("reset test done");
    foreach (rows[i])
    begin
      cur_fmt = rows[i].fmt;
      m_tx = rows[i].stx;
      len = rows[i].fmt[FMT_CHR] ? 16 : 8;
      msk = rows[i].fmt[FMT_CHR] ? 16'hffff : 16'h00ff;
      wr(OFF_FMT, {8'h00, rows[i].fmt});
      wr(OFF_DIV, {8'h00, rows[i].div});
      wr(OFF_CTRL, 16'h0003);
      wr(OFF_IRQ_STAT, 16'h000f);
      rd(OFF_FMT);
      chk("format", {8'h00, rows[i].fmt & FMT_RW_MASK}, got);
      rd(OFF_DIV);
      chk("divider", {8'h00, rows[i].div}, got);
      m_sel_n = 1'b0;
      tog = 0;
      wr(OFF_DATA, rows[i].tx);
      wait_idle();
      chk("toggles", 16'(2 * len), 16'(tog));
      chk("span", 16'((2 * len - 1) * (int'(rows[i].div) + 1)), 16'(t_last - t_first));
      chk("sclk idle", {15'h0, rows[i].fmt[FMT_CPOL]}, {15'h0, spi_o.sclk_o});
      chk("slave rx", rows[i].tx & msk, m_rx & msk);
      rd(OFF_DATA);
      chk("master rx", rows[i].stx & msk, got & msk);
      chk("irq", {15'h0, rows[i].fmt[FMT_IRQEN]}, {15'h0, irq_o});
      m_sel_n = 1'b1;
      $display("row %0d done", i);
    end
    wr(OFF_FMT, 16'h0080);
    for (int b = 0; b < 4; b++)
    begin
      wr(OFF_IRQ_MASK, 16'h0000);
      wr(OFF_CTRL, 16'h0001 | (16'h0008 << b));
      chk("irq masked", 16'h0000, {15'h0, irq_o});
      wr(OFF_IRQ_MASK, 16'h0001 << b);
      chk("irq raised", 16'h0001, {15'h0, irq_o});
      wr(OFF_IRQ_STAT, 16'h000f);
      chk("irq cleared", 16'h0000, {15'h0, irq_o});
    end
    wr(OFF_CTRL, 16'h0041);
    wr(OFF_FMT, 16'h0000);
    chk("irq disabled", 16'h0000, {15'h0, irq_o});
    wr(OFF_IRQ_STAT, 16'h000f);
    $display("irq test done");
    cur_fmt = 8'h00;
    wr(OFF_DIV, 16'h0004);
    wr(OFF_CTRL, 16'h0003);
    m_sel_n = 1'b0;
    wr(OFF_DATA, 16'h0011);
    wr(OFF_DATA, 16'h0022);
    rd(OFF_CTRL);
    chk("busy write_collision_flag", 16'h0093, got);
    wr(OFF_CTRL, 16'h0002);
    rd(OFF_CTRL);
    chk("abort", 16'h0002, got);
    chk("sclk oe off", 16'h0000, {15'h0, spi_o.sclk_oe});
    m_sel_n = 1'b1;
    wr(OFF_CTRL, 16'h0001);
    chk("slave oe", 16'h0000, {14'h0, spi_o.sclk_oe, spi_o.mosi_oe});
    wr(OFF_CTRL, 16'h0000);
    @(posedge clk_sys) ssel_n <= 1'b0;
    wr(OFF_CTRL, 16'h0002);
    rd(OFF_CTRL);
    chk("master refused", 16'h0000, got);
    @(posedge clk_sys) ssel_n <= 1'b1;
    wr(OFF_CTRL, 16'h0002);
    rd(OFF_CTRL);
    chk("master taken", 16'h0002, got);
    $display("control test done");
    wr(OFF_IRQ_STAT, 16'h000f);
    wr(OFF_CTRL, 16'h0007);
    wr(OFF_DATA, 16'h0055);
    @(posedge clk_sys) ssel_n <= 1'b0;
    rd(OFF_CTRL);
    chk("mode fault", 16'h000f, got);
    rd(OFF_IRQ_STAT);
    chk("mode_fault_flag status", 16'h0001, got);
    @(posedge clk_sys) ssel_n <= 1'b1;
    $display("mode fault test done");
    // bench acts as the external master, mode 0, 8 bit
    wr(OFF_CTRL, 16'h0001);
    wr(OFF_DATA, 16'h00c5);
    @(posedge clk_sys) ssel_n <= 1'b0;
    for (int b = 7; b >= 0; b--)
    begin
      @(posedge clk_sys) s_mosi <= EXT_WORD[b];
      @(posedge clk_sys) s_sclk <= 1'b1;
      #1 ext_got[b] = spi_o.miso_o;
      chk("miso oe", 16'h0001, {15'h0, spi_o.miso_oe});
      @(posedge clk_sys) s_sclk <= 1'b0;
    end
    @(posedge clk_sys) ssel_n <= 1'b1;
    rd(OFF_DATA);
    chk("ext rx", {8'h00, EXT_WORD}, got);
    chk("ext tx", 16'h00c5, {8'h00, ext_got});
    rd(OFF_CTRL);
    chk("ext done", 16'h0041, got);
    $display("slave test done");
    @(posedge clk_sys) reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    rd(OFF_DIV);
    chk("second reset", 16'h0000, got);
    $display("second reset test done");
    summarize();
  end
endmodule
